// ### inc/acc_pkg.sv
// package for the converter control block: map, fields, timing
`default_nettype none
package acc_pkg;
    localparam logic [7:0] OFF_SC1 = 8'h00;
    localparam logic [7:0] OFF_SC2 = 8'h04;
    localparam logic [7:0] OFF_RESULT_LOW = 8'h08;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h0c;
    localparam logic [7:0] OFF_COMPARE_LOW = 8'h10;
    localparam logic [7:0] OFF_COMPARE_HIGH = 8'h14;
    localparam int SC1_DONE_BIT = 7;
    localparam int SC1_IEN_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRIG_BIT = 6;
    localparam int SC2_CMPEN_BIT = 5;
    localparam int SC2_CMPGT_BIT = 4;
    localparam logic [4:0] CH_RESERVED = 5'h1c;
    localparam logic [4:0] CH_HIGH_REF = 5'h1d;
    localparam logic [4:0] CH_LOW_REF = 5'h1e;
    localparam logic [4:0] CH_DISABLE = 5'h1f;
    localparam logic [4:0] CH_RESET = CH_DISABLE;
    localparam int CONV_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    typedef struct packed {
        logic done_interrupt_enable;
        logic continuous_enable;
        logic [4:0] channel_select;
    } acc_sc1_s;
    typedef struct packed {
        logic trigger_select;
        logic compare_enable;
        logic compare_greater;
    } acc_sc2_s;
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT} acc_state_e;
endpackage : acc_pkg
`default_nettype wire

// ### logic/acc_trigger_sync.sv
// trigger synchroniser and rising edge detector
`timescale 1ns/1ps
`default_nettype none
module acc_trigger_sync (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic trig_in,
    output logic trig_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= trig_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign trig_pulse = sync_reg & ~last_reg;
endmodule : acc_trigger_sync
`default_nettype wire

// ### logic/acc_conversion_control.sv
// converter control: status/control registers, sequencing, ahb-lite slave
// Operation
// - any write to control one aborts, and restarts only with software trigger selected, unless channel is all ones
// - done flag is read only; writes never set it
// - compare off: done flag sets at every conversion end
// - compare on: done flag sets only when compare holds
// - done flag clears on control one write or result low read
// - interrupt request when done flag sets with enable high
// - continuous off: one conversion per write or trigger
// - continuous on: back to back conversions after write or trigger
// - channel field is bits 4 to 0 of control one
// - codes 0..27 inputs, 28 reserved, 29 high ref, 30 low ref
// - all ones channel powers converter off and isolates input
// - leaving continuous via all ones runs no extra conversion
// - single mode returns to low power idle after each conversion
// - trigger select in control two picks software or hardware start
// - compare enable in control two gates done flag setting
// - active bit set at start, cleared at completion or abort
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acc_conversion_control #(
    parameter int CONV_CYCLES = acc_pkg::CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hardware_trigger_input,
    input wire logic [9:0] sample_result,
    output logic [4:0] mux_select,
    output logic mux_isolate,
    output logic converter_power,
    output logic sample_start,
    output logic conversion_done_irq
);
    ////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_reg;
    logic addr_phase;
    assign addr_phase = hsel
        & hready
        & (htrans == acc_pkg::HTRANS_NONSEQ);

    // write data phase follows a write address phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
        end
    end

    // address kept for the data phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= 8'h00;
        end else if (addr_phase) begin
            addr_reg <= haddr;
        end
    end

    logic wr_sc1;
    logic wr_sc2;
    logic rd_low;
    logic rd_now;
    assign wr_sc1 = wr_pend_reg & (addr_reg == acc_pkg::OFF_SC1);
    assign wr_sc2 = wr_pend_reg & (addr_reg == acc_pkg::OFF_SC2);
    assign rd_now = addr_phase & ~hwrite;
    assign rd_low = rd_now & (haddr == acc_pkg::OFF_RESULT_LOW);

    ////////////////////////////////////////////////////////////////////
    // trigger
    logic hw_trig;
    acc_trigger_sync u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .trig_in(hardware_trigger_input),
        .trig_pulse(hw_trig)
    );

    ////////////////////////////////////////////////////////////////////
    // registers
    acc_pkg::acc_sc1_s sc1_reg;
    acc_pkg::acc_sc2_s sc2_reg;
    logic [9:0] cmp_reg;
    logic [9:0] result_reg;
    logic done_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sc1_reg <= '{1'b0, 1'b0, acc_pkg::CH_RESET};
        end else if (wr_sc1) begin
            sc1_reg.done_interrupt_enable <= hwdata[acc_pkg::SC1_IEN_BIT];
            sc1_reg.continuous_enable <= hwdata[acc_pkg::SC1_CONT_BIT];
            sc1_reg.channel_select <= hwdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sc2_reg <= '0;
        end else if (wr_sc2) begin
            sc2_reg.trigger_select <= hwdata[acc_pkg::SC2_TRIG_BIT];
            sc2_reg.compare_enable <= hwdata[acc_pkg::SC2_CMPEN_BIT];
            sc2_reg.compare_greater <= hwdata[acc_pkg::SC2_CMPGT_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmp_reg <= 10'h000;
        end else if (wr_pend_reg && addr_reg == acc_pkg::OFF_COMPARE_LOW) begin
            cmp_reg[7:0] <= hwdata[7:0];
        end else if (wr_pend_reg && addr_reg == acc_pkg::OFF_COMPARE_HIGH) begin
            cmp_reg[9:8] <= hwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer
    acc_pkg::acc_state_e state_reg;
    logic [15:0] count_reg;
    logic conv_end;
    logic start_req;
    logic cmp_true;
    logic disabled_next;
    logic sw_start;
    logic cont_again;
    assign conv_end = (state_reg == acc_pkg::ST_CONVERT)
        && (count_reg == 16'(CONV_CYCLES - 1));
    assign disabled_next = (hwdata[4:0] == acc_pkg::CH_DISABLE);
    assign sw_start = wr_sc1 && !disabled_next && !sc2_reg.trigger_select;
    assign cont_again = conv_end && sc1_reg.continuous_enable;

    // software start on write, hardware start on trigger edge
    always_comb begin
        start_req = 1'b0;
        if (sc1_reg.channel_select != acc_pkg::CH_DISABLE) begin
            if (sc2_reg.trigger_select) begin
                start_req = hw_trig;
            end else if (cont_again) begin
                start_req = 1'b1;
            end
            if (sc2_reg.trigger_select && cont_again) begin
                start_req = 1'b1;
            end
        end
    end

    // compare condition on the result being finished
    assign cmp_true = sc2_reg.compare_greater
        ? (sample_result >= cmp_reg)
        : (sample_result < cmp_reg);

    // idle or converting; a control one write always wins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= acc_pkg::ST_IDLE;
        end else if (wr_sc1) begin
            if (disabled_next) begin
                state_reg <= acc_pkg::ST_IDLE;
            end else if (!sc2_reg.trigger_select) begin
                state_reg <= acc_pkg::ST_CONVERT;
            end else begin
                state_reg <= acc_pkg::ST_IDLE;
            end
        end else if (start_req) begin
            state_reg <= acc_pkg::ST_CONVERT;
        end else if (conv_end) begin
            state_reg <= acc_pkg::ST_IDLE;
        end
    end

    // conversion time counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 16'h0000;
        end else if (wr_sc1 || start_req || conv_end) begin
            count_reg <= 16'h0000;
        end else if (state_reg == acc_pkg::ST_CONVERT) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // one pulse per conversion start
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sample_start <= 1'b0;
        end else begin
            sample_start <= sw_start
                || (!wr_sc1 && start_req);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result and done flag
    logic done_set;
    assign done_set = conv_end
        && !wr_sc1
        && (!sc2_reg.compare_enable || cmp_true);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            result_reg <= 10'h000;
        end else if (done_set) begin
            result_reg <= sample_result;
        end
    end

    // no write path sets the flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else if (done_set) begin
            done_reg <= 1'b1;
        end else if (wr_sc1 || rd_low) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            conversion_done_irq <= 1'b0;
        end else begin
            conversion_done_irq <= sc1_reg.done_interrupt_enable & (done_reg | done_set);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog side controls
    logic [4:0] ch_use;
    assign ch_use = wr_sc1 ? hwdata[4:0] : sc1_reg.channel_select;

    // channel code to the input mux
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mux_select <= acc_pkg::CH_RESET;
        end else begin
            mux_select <= ch_use;
        end
    end

    // input cut off for disable and reserved codes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mux_isolate <= 1'b1;
        end else begin
            mux_isolate <= (ch_use == acc_pkg::CH_DISABLE)
                || (ch_use == acc_pkg::CH_RESERVED);
        end
    end

    // converter powered only while a conversion runs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            converter_power <= 1'b0;
        end else begin
            converter_power <= (state_reg == acc_pkg::ST_CONVERT)
                && !conv_end
                && !wr_sc1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    logic active;
    assign active = (state_reg == acc_pkg::ST_CONVERT);
    always_comb begin
        rdata_reg = 32'h0000_0000;
        unique case (haddr)
            acc_pkg::OFF_SC1: begin
                rdata_reg[acc_pkg::SC1_DONE_BIT] = done_reg;
                rdata_reg[acc_pkg::SC1_IEN_BIT] = sc1_reg.done_interrupt_enable;
                rdata_reg[acc_pkg::SC1_CONT_BIT] = sc1_reg.continuous_enable;
                rdata_reg[4:0] = sc1_reg.channel_select;
            end
            acc_pkg::OFF_SC2: begin
                rdata_reg[acc_pkg::SC2_ACTIVE_BIT] = active;
                rdata_reg[acc_pkg::SC2_TRIG_BIT] = sc2_reg.trigger_select;
                rdata_reg[acc_pkg::SC2_CMPEN_BIT] = sc2_reg.compare_enable;
                rdata_reg[acc_pkg::SC2_CMPGT_BIT] = sc2_reg.compare_greater;
            end
            acc_pkg::OFF_RESULT_LOW: begin
                rdata_reg[7:0] = result_reg[7:0];
            end
            acc_pkg::OFF_RESULT_HIGH: begin
                rdata_reg[1:0] = result_reg[9:8];
            end
            acc_pkg::OFF_COMPARE_LOW: begin
                rdata_reg[7:0] = cmp_reg[7:0];
            end
            acc_pkg::OFF_COMPARE_HIGH: begin
                rdata_reg[1:0] = cmp_reg[9:8];
            end
            default: rdata_reg = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_now) begin
            hrdata <= rdata_reg;
        end
    end

    // zero wait states
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // every transfer answered okay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= acc_pkg::HRESP_OKAY[0];
        end
    end
endmodule : acc_conversion_control
`default_nettype wire

// ### verif/acc_analog_model.sv
// far side model: trigger source and analog input mux
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [4:0] mux_select,
    input wire logic mux_isolate,
    output logic hardware_trigger_input,
    output logic [9:0] sample_result
);
    logic [9:0] noise = 10'h2aa;
    initial hardware_trigger_input = 1'b0;
    always @(posedge clk_sys) begin
        hardware_trigger_input <= fire;
        noise <= ~noise;
    end
    // isolated input holds no stable level
    assign sample_result = mux_isolate ? noise : {mux_select, 5'h05};
endmodule : acc_analog_model
`default_nettype wire

// ### verif/acc_conversion_control_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_conversion_control_chk #(
    parameter int CONV_CYCLES = acc_pkg::CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [4:0] mux_select,
    input wire logic mux_isolate,
    input wire logic converter_power,
    input wire logic sample_start
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    int run;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) run <= 0;
        else if (sample_start || !converter_power) run <= 0;
        else run <= run + 1;
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_unmapped_zero: assert property (hsel && hready && htrans == acc_pkg::HTRANS_NONSEQ && !hwrite
        && haddr == 8'h18 |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_start_single: assert property (sample_start |=> !sample_start) else $error("start pulse too long");
    a_start_powers: assert property (sample_start |=> converter_power) else $error("start without power");
    a_start_enabled: assert property (sample_start |=> mux_select != 5'h1f) else $error("start while off");
    a_isolate_code: assert property (mux_isolate == (mux_select == 5'h1f || mux_select == 5'h1c))
        else $error("isolate does not follow code");
    a_power_bounded: assert property (run <= CONV_CYCLES + 2) else $error("converter stays powered");
    a_reset_disabled: assert property ($rose(resetn) |-> mux_select == 5'h1f && mux_isolate && !converter_power)
        else $error("reset state not disabled");
endmodule : acc_conversion_control_chk
bind acc_conversion_control acc_conversion_control_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clk_sys(clk_sys),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mux_select(mux_select), .mux_isolate(mux_isolate),
    .converter_power(converter_power), .sample_start(sample_start));
`default_nettype wire

// ### verif/tb_acc_conversion_control.sv
// testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_acc_conversion_control;
    localparam int CC = 6;
    logic clk_sys = 0, resetn = 0, hsel = 0, hwrite = 0, fire = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp, trig, start, irq, iso, pwr;
    logic [9:0] res;
    logic [4:0] msel;
    logic [4:0] chans [4] = '{5'h03, 5'h1b, 5'h1d, 5'h1e};
    int fails = 0, checked = 0, starts = 0, n, k0;
    acc_conversion_control #(.CONV_CYCLES(CC)) uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hardware_trigger_input(trig),
        .sample_result(res), .mux_select(msel), .mux_isolate(iso), .converter_power(pwr),
        .sample_start(start), .conversion_done_irq(irq));
    acc_analog_model u_far (.clk_sys(clk_sys), .fire(fire), .mux_select(msel), .mux_isolate(iso),
        .hardware_trigger_input(trig), .sample_result(res));
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (start === 1'b1) starts++;
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic tick;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            stop_test;
        end
    endtask : tick
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= acc_pkg::HTRANS_NONSEQ;
        tick;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        tick;
        r = hrdata;
    endtask : bus
    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, r, e);
    endtask : rd
    task automatic wait_done;
        r = 32'h0;
        for (int i = 0; i < 20 && r[7] !== 1'b1; i++) bus(1'b0, acc_pkg::OFF_SC1, 32'h0);
        if (r[7] !== 1'b1) begin
            fails++;
            stop_test;
        end
    endtask : wait_done
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        rd("sc1 reset", acc_pkg::OFF_SC1, 32'h1f);
        chk("isolate", {31'h0, iso}, 32'h1);
        bus(1'b1, acc_pkg::OFF_SC2, 32'h80);
        rd("sc2 reset", acc_pkg::OFF_SC2, 32'h0);
        rd("unmapped", 8'h18, 32'h0);
        $display("test reset done");
        foreach (chans[i]) begin
            bus(1'b1, acc_pkg::OFF_SC1, {24'h0, 1'b1, i == 0, 1'b0, chans[i]});
            rd("sc1 busy", acc_pkg::OFF_SC1, {25'h0, i == 0, 1'b0, chans[i]});
            rd("sc2 busy", acc_pkg::OFF_SC2, 32'h80);
            chk("mux", {27'h0, msel}, {27'h0, chans[i]});
            wait_done;
            chk("irq", {31'h0, irq}, {31'h0, i == 0});
            chk("power", {31'h0, pwr}, 32'h0);
            rd("sc2 idle", acc_pkg::OFF_SC2, 32'h0);
            rd("result", acc_pkg::OFF_RESULT_LOW, {24'h0, chans[i][2:0], 5'h05});
            rd("sc1 clear", acc_pkg::OFF_SC1, {25'h0, i == 0, 1'b0, chans[i]});
        end
        $display("test single done");
        k0 = starts;
        bus(1'b1, acc_pkg::OFF_SC1, 32'h22);
        repeat (3 * CC + 4) @(posedge clk_sys);
        chk("repeats", {31'h0, starts - k0 >= 3}, 32'h1);
        bus(1'b1, acc_pkg::OFF_SC1, 32'h1f);
        k0 = starts;
        repeat (3 * CC) @(posedge clk_sys);
        chk("no extra", 32'(starts - k0), 32'h0);
        rd("sc1 off", acc_pkg::OFF_SC1, 32'h1f);
        chk("off power", {31'h0, pwr}, 32'h0);
        bus(1'b1, acc_pkg::OFF_SC1, 32'h1c);
        @(posedge clk_sys);
        chk("reserved isolate", {31'h0, iso}, 32'h1);
        $display("test continuous done");
        bus(1'b1, acc_pkg::OFF_SC2, 32'h30);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, acc_pkg::OFF_COMPARE_LOW, j ? 32'h0 : 32'hff);
            bus(1'b1, acc_pkg::OFF_COMPARE_HIGH, j ? 32'h0 : 32'h3);
            bus(1'b1, acc_pkg::OFF_SC1, 32'h03);
            repeat (3 * CC) @(posedge clk_sys);
            rd("compare", acc_pkg::OFF_SC1, {24'h0, j[0], 7'h03});
        end
        $display("test compare done");
        bus(1'b1, acc_pkg::OFF_SC2, 32'h40);
        bus(1'b1, acc_pkg::OFF_SC1, 32'h04);
        k0 = starts;
        repeat (3 * CC) @(posedge clk_sys);
        fire <= 1'b1;
        repeat (5) @(posedge clk_sys);
        fire <= 1'b0;
        repeat (3 * CC) @(posedge clk_sys);
        chk("hw starts", 32'(starts - k0), 32'h1);
        rd("hw done", acc_pkg::OFF_SC1, 32'h84);
        $display("test trigger done");
        stop_test;
    end
endmodule : tb_acc_conversion_control
`default_nettype wire
